// File: hdl/ccb_pkg.sv
// ccb_pkg: shared constants and types for the cache-block operation checker.
// assumes: one core clock domain; the AXI4-Lite register window sits on byte addresses.
package ccb_pkg;
	// ----------------------------------------
	// operation, state and answer encodings
	// ----------------------------------------
	typedef enum logic [2:0] {
		CCB_OP_CLEAN = 3'h0,
		CCB_OP_FLUSH = 3'h1,
		CCB_OP_INVAL = 3'h2,
		CCB_OP_ZERO = 3'h3,
		CCB_OP_PREF_I = 3'h4,
		CCB_OP_PREF_R = 3'h5
	} ccb_op_t;
	typedef enum logic [4:0] {
		CCB_CAUSE_NONE = 5'h00,
		CCB_CAUSE_TAG = 5'h01,
		CCB_CAUSE_SEAL = 5'h02,
		CCB_CAUSE_PERM = 5'h03,
		CCB_CAUSE_LEN = 5'h04
	} ccb_cause_t;
	typedef enum logic [1:0] {
		CCB_ST_IDLE = 2'b00,
		CCB_ST_ZERO = 2'b01
	} ccb_state_t;
	localparam logic [3:0] CCB_TYPE_NONE = 4'h0;
	localparam logic [3:0] CCB_TYPE_DATA = 4'h1;
	// ----------------------------------------
	// permission bits, privilege, inval_behaviour_field
	// ----------------------------------------
	localparam int CCB_PERM_X = 0;
	localparam int CCB_PERM_R = 1;
	localparam int CCB_PERM_W = 2;
	localparam int CCB_PERM_ASR = 3;
	localparam logic [1:0] CCB_PRIV_U = 2'h0;
	localparam logic [1:0] CCB_PRIV_S = 2'h1;
	localparam logic [1:0] CCB_PRIV_M = 2'h3;
	localparam logic [1:0] CCB_INV_FLUSH = 2'h1;
	localparam int CCB_IMM_LOW = 5;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] CCB_REG_ENV = 8'h00;
	localparam logic [7:0] CCB_REG_STATUS = 8'h04;
	localparam logic [7:0] CCB_REG_FADDR = 8'h08;
	localparam logic [3:0] CCB_ENV_RESET = 4'hF;
	localparam int CCB_ENV_M_POS = 0;
	localparam int CCB_ENV_S_POS = 2;
	localparam int CCB_ST_FAULT_POS = 5;
	localparam int CCB_ST_BUSY_POS = 6;
	localparam int CCB_ST_OP_POS = 8;
	localparam logic [1:0] CCB_RESP_OKAY = 2'h0;
	localparam logic [1:0] CCB_RESP_SLVERR = 2'h2;
endpackage

// File: hdl/ccb_check.sv
// ccb_check: authority checks and operation selection for cache-block operations.
// assumes: pipeline holds a request while req_ready_o is low; cache takes commands without stalling.
// Operation
// - capability mode cleans block at authorising_cap_reg address, that register authorising.
// - legacy mode uses integer_base_reg address, default data capability authorising.
// - flush flushes block at effective address, register capability authorising.
// - invalidate invalidates the block unless inval_behaviour_field turns it into flush.
// - capability mode always authorises with authorising_cap_reg.
// - failed check raises data fault, data-fault type and cause code recorded.
// - tag of zero gives tag violation.
// - sealed authority gives seal violation.
// - clean and flush need write and read permission.
// - invalidate needs write, read and system_reg_access_perm.
// - invalidate and zero need whole block inside bounds.
// - inval_behaviour_field picks flush instead of invalidate for lower privilege.
// - invalidate checks ignore inval_behaviour_field and privilege.
// - zero writes zeros over every byte of the block.
// - each zero write clears the tag of its capability_width location.
// - zero needs write permission.
// - prefetch address is base plus sign-extended 12-bit immediate.
// - prefetch encoding valid only when immediate low five bits are zero.
// - prefetches are hints only: instruction fetch or data read.
// - instruction prefetch needs execute permission.
// - data-read prefetch needs read permission.
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module ccb_check #(
	parameter int XLEN = 32,
	parameter int BLK_BYTES = 64,
	parameter int CAP_BYTES = 8
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// request from pipeline
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire ccb_pkg::ccb_op_t req_op_i,
	input wire logic req_cap_mode_i,
	input wire logic [1:0] req_priv_i,
	input wire logic [11:0] req_imm_i,
	input wire logic [XLEN-1:0] integer_base_reg_i,
	// authorising_cap_reg
	input wire logic [XLEN-1:0] acap_addr_i,
	input wire logic acap_tag_i,
	input wire logic acap_sealed_i,
	input wire logic [3:0] acap_perm_i,
	input wire logic [XLEN-1:0] acap_bot_i,
	input wire logic [XLEN:0] acap_top_i,
	// default data capability
	input wire logic ddc_tag_i,
	input wire logic ddc_sealed_i,
	input wire logic [3:0] ddc_perm_i,
	input wire logic [XLEN-1:0] ddc_bot_i,
	input wire logic [XLEN:0] ddc_top_i,
	// answer to pipeline
	output logic resp_valid_o,
	output logic resp_fault_o,
	output ccb_pkg::ccb_cause_t resp_cause_o,
	output logic [3:0] resp_type_o,
	// command to cache
	output logic cmd_valid_o,
	output ccb_pkg::ccb_op_t cmd_op_o,
	output logic [XLEN-1:0] cmd_addr_o,
	// zero writes to cache
	output logic zwr_valid_o,
	input wire logic zwr_ready_i,
	output logic [XLEN-1:0] zwr_addr_o,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import ccb_pkg::*;

	localparam int ZCNT = BLK_BYTES / CAP_BYTES;
	localparam int ZW = $clog2(ZCNT) + 1;
	localparam logic [ZW-1:0] ZLAST = ZW'(ZCNT - 1);
	localparam logic [XLEN-1:0] BLK_MASK = ~XLEN'(BLK_BYTES - 1);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		ccb_state_t st;
		logic aw_seen;
		logic [7:0] aw_addr;
		logic w_seen;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [1:0] env_m;
		logic [1:0] env_s;
		logic last_fault;
		ccb_cause_t last_cause;
		ccb_op_t last_op;
		logic [XLEN-1:0] fault_addr;
		logic resp_valid;
		logic resp_fault;
		ccb_cause_t resp_cause;
		logic [3:0] resp_type;
		logic cmd_valid;
		ccb_op_t cmd_op;
		logic [XLEN-1:0] cmd_addr;
		logic zwr_valid;
		logic [XLEN-1:0] zwr_addr;
		logic [ZW-1:0] zcnt;
	} ccb_state_s_t;

	ccb_state_s_t r;
	ccb_state_s_t next_r;
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic blk_inside(input logic [XLEN-1:0] blk, input logic [XLEN-1:0] bot,
		input logic [XLEN:0] top);
		logic [XLEN:0] end_a;
		end_a = {1'b0, blk} + (XLEN+1)'(BLK_BYTES);
		return (blk >= bot) && (end_a <= top);
	endfunction

	// ----------------------------------------
	// authority check
	// ----------------------------------------
	logic a_tag;
	logic a_sealed;
	logic [3:0] a_perm;
	logic [XLEN-1:0] a_bot;
	logic [XLEN:0] a_top;
	logic [XLEN-1:0] base;
	logic [XLEN-1:0] ea;
	logic [XLEN-1:0] blk;
	logic is_pref;
	logic pref_bad;
	logic perm_ok;
	logic len_ok;
	logic accept;
	ccb_cause_t chk_cause;
	ccb_op_t op_eff;

	always_comb begin
		a_tag = req_cap_mode_i ? acap_tag_i : ddc_tag_i;
		a_sealed = req_cap_mode_i ? acap_sealed_i : ddc_sealed_i;
		a_perm = req_cap_mode_i ? acap_perm_i : ddc_perm_i;
		a_bot = req_cap_mode_i ? acap_bot_i : ddc_bot_i;
		a_top = req_cap_mode_i ? acap_top_i : ddc_top_i;
		base = req_cap_mode_i ? acap_addr_i : integer_base_reg_i;
		is_pref = (req_op_i == CCB_OP_PREF_I) || (req_op_i == CCB_OP_PREF_R);
		ea = is_pref ? base + {{(XLEN-12){req_imm_i[11]}}, req_imm_i} : base;
		blk = ea & BLK_MASK;
		pref_bad = is_pref && (req_imm_i[CCB_IMM_LOW-1:0] != 5'h00);
		len_ok = blk_inside(blk, a_bot, a_top);
		perm_ok = 1'b0;
		case (req_op_i)
			CCB_OP_CLEAN, CCB_OP_FLUSH: perm_ok = a_perm[CCB_PERM_W] && a_perm[CCB_PERM_R];
			CCB_OP_INVAL: perm_ok = a_perm[CCB_PERM_W] && a_perm[CCB_PERM_R] && a_perm[CCB_PERM_ASR];
			CCB_OP_ZERO: perm_ok = a_perm[CCB_PERM_W];
			CCB_OP_PREF_I: perm_ok = a_perm[CCB_PERM_X];
			CCB_OP_PREF_R: perm_ok = a_perm[CCB_PERM_R];
			default: perm_ok = 1'b0;
		endcase
		if (!a_tag) begin
			chk_cause = CCB_CAUSE_TAG;
		end else if (a_sealed) begin
			chk_cause = CCB_CAUSE_SEAL;
		end else if (!perm_ok) begin
			chk_cause = CCB_CAUSE_PERM;
		end else if (!len_ok) begin
			chk_cause = CCB_CAUSE_LEN;
		end else begin
			chk_cause = CCB_CAUSE_NONE;
		end
		if (pref_bad) begin
			chk_cause = CCB_CAUSE_NONE;
		end
		op_eff = req_op_i;
		if (req_op_i == CCB_OP_INVAL) begin
			if ((req_priv_i != CCB_PRIV_M) && (r.env_m == CCB_INV_FLUSH)) begin
				op_eff = CCB_OP_FLUSH;
			end else if ((req_priv_i == CCB_PRIV_U) && (r.env_s == CCB_INV_FLUSH)) begin
				op_eff = CCB_OP_FLUSH;
			end
		end
		accept = req_valid_i && (r.st == CCB_ST_IDLE) && !r.zwr_valid;
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_r = r;
		next_r.resp_valid = 1'b0;
		next_r.cmd_valid = 1'b0;
		if (accept) begin
			next_r.resp_valid = 1'b1;
			next_r.resp_fault = (chk_cause != CCB_CAUSE_NONE);
			next_r.resp_cause = chk_cause;
			next_r.resp_type = (chk_cause != CCB_CAUSE_NONE) ? CCB_TYPE_DATA : CCB_TYPE_NONE;
			next_r.last_op = req_op_i;
			if (chk_cause != CCB_CAUSE_NONE) begin
				next_r.last_fault = 1'b1;
				next_r.last_cause = chk_cause;
				next_r.fault_addr = ea;
			end else if (pref_bad) begin
				next_r.cmd_valid = 1'b0;
			end else if (req_op_i == CCB_OP_ZERO) begin
				next_r.st = CCB_ST_ZERO;
				next_r.zwr_valid = 1'b1;
				next_r.zwr_addr = blk;
				next_r.zcnt = '0;
			end else begin
				next_r.cmd_valid = 1'b1;
				next_r.cmd_op = op_eff;
				next_r.cmd_addr = blk;
			end
		end
		case (r.st)
			CCB_ST_ZERO: begin
				if (zwr_ready_i) begin
					if (r.zcnt == ZLAST) begin
						next_r.zwr_valid = 1'b0;
						next_r.st = CCB_ST_IDLE;
					end else begin
						next_r.zcnt = r.zcnt + ZW'(1);
						next_r.zwr_addr = r.zwr_addr + XLEN'(CAP_BYTES);
					end
				end
			end
			default: ;
		endcase
		if (s_axi_awvalid && s_axi_awready) begin
			next_r.aw_seen = 1'b1;
			next_r.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_r.w_seen = 1'b1;
			next_r.wdata = s_axi_wdata;
			next_r.wstrb = s_axi_wstrb;
		end
		if (r.aw_seen && r.w_seen && !r.bvalid) begin
			next_r.aw_seen = 1'b0;
			next_r.w_seen = 1'b0;
			next_r.bvalid = 1'b1;
			next_r.bresp = CCB_RESP_OKAY;
			if (r.aw_addr == CCB_REG_ENV) begin
				if (r.wstrb[0]) begin
					next_r.env_m = r.wdata[CCB_ENV_M_POS +: 2];
					next_r.env_s = r.wdata[CCB_ENV_S_POS +: 2];
				end
			end else if (r.aw_addr == CCB_REG_STATUS) begin
				if (r.wstrb[0] && r.wdata[CCB_ST_FAULT_POS] && !(accept && chk_cause != CCB_CAUSE_NONE)) begin
					next_r.last_fault = 1'b0;
				end
			end else if (r.aw_addr != CCB_REG_FADDR) begin
				next_r.bresp = CCB_RESP_SLVERR;
			end
		end
		if (r.bvalid && s_axi_bready) begin
			next_r.bvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_r.rvalid = 1'b1;
			next_r.rresp = CCB_RESP_OKAY;
			next_r.rdata = 32'h0000_0000;
			if (s_axi_araddr == CCB_REG_ENV) begin
				next_r.rdata[CCB_ENV_M_POS +: 2] = r.env_m;
				next_r.rdata[CCB_ENV_S_POS +: 2] = r.env_s;
			end else if (s_axi_araddr == CCB_REG_STATUS) begin
				next_r.rdata[4:0] = r.last_cause;
				next_r.rdata[CCB_ST_FAULT_POS] = r.last_fault;
				next_r.rdata[CCB_ST_BUSY_POS] = (r.st != CCB_ST_IDLE);
				next_r.rdata[CCB_ST_OP_POS +: 3] = r.last_op;
			end else if (s_axi_araddr == CCB_REG_FADDR) begin
				next_r.rdata = 32'(r.fault_addr);
			end else begin
				next_r.rresp = CCB_RESP_SLVERR;
			end
		end else if (r.rvalid && s_axi_rready) begin
			next_r.rvalid = 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			r <= '0;
			r.st <= CCB_ST_IDLE;
			r.env_m <= CCB_ENV_RESET[1:0];
			r.env_s <= CCB_ENV_RESET[3:2];
			r.resp_cause <= CCB_CAUSE_NONE;
			r.last_cause <= CCB_CAUSE_NONE;
			r.cmd_op <= CCB_OP_CLEAN;
			r.last_op <= CCB_OP_CLEAN;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign req_ready_o = (r.st == CCB_ST_IDLE) && !r.zwr_valid;
	assign resp_valid_o = r.resp_valid;
	assign resp_fault_o = r.resp_fault;
	assign resp_cause_o = r.resp_cause;
	assign resp_type_o = r.resp_type;
	assign cmd_valid_o = r.cmd_valid;
	assign cmd_op_o = r.cmd_op;
	assign cmd_addr_o = r.cmd_addr;
	assign zwr_valid_o = r.zwr_valid;
	assign zwr_addr_o = r.zwr_addr;
	assign s_axi_awready = !r.aw_seen && !r.bvalid;
	assign s_axi_wready = !r.w_seen && !r.bvalid;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_bresp = r.bresp;
	assign s_axi_arready = !r.rvalid;
	assign s_axi_rvalid = r.rvalid;
	assign s_axi_rdata = r.rdata;
	assign s_axi_rresp = r.rresp;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	sequence s_zero_go;
		accept && (req_op_i == CCB_OP_ZERO) && (chk_cause == CCB_CAUSE_NONE);
	endsequence
	sequence s_zero_run;
		zwr_valid_o && (zwr_addr_o == $past(blk)) && !req_ready_o;
	endsequence

	AST_TAG_FIRST: assert property (accept && !a_tag && !pref_bad
		|=> resp_valid_o && resp_cause_o == CCB_CAUSE_TAG)
		else $error("tag fault not reported first");
	AST_SEAL: assert property (accept && a_tag && a_sealed && !pref_bad |=> resp_cause_o == CCB_CAUSE_SEAL)
		else $error("seal fault not reported");
	AST_INV_PERM: assert property (accept && a_tag && !a_sealed && req_op_i == CCB_OP_INVAL && !a_perm[CCB_PERM_ASR]
		|=> resp_cause_o == CCB_CAUSE_PERM)
		else $error("invalidate without system register permission not refused");
	AST_ZERO_PERM: assert property (accept && a_tag && !a_sealed && req_op_i == CCB_OP_ZERO && !a_perm[CCB_PERM_W]
		|=> resp_fault_o && !zwr_valid_o)
		else $error("zero without write permission not refused");
	AST_FAULT_TYPE: assert property (resp_valid_o && resp_fault_o |-> resp_type_o == CCB_TYPE_DATA && !cmd_valid_o)
		else $error("fault without data fault type or with a command");
	AST_PREF_BAD: assert property (accept && pref_bad |=> resp_valid_o && !resp_fault_o && !cmd_valid_o)
		else $error("malformed prefetch not ignored");
	AST_INV_M: assert property (accept && req_op_i == CCB_OP_INVAL && chk_cause == CCB_CAUSE_NONE && req_priv_i == CCB_PRIV_M
		|=> cmd_valid_o && cmd_op_o == CCB_OP_INVAL)
		else $error("machine mode invalidate changed to flush");
	AST_ZERO_START: assert property (s_zero_go |=> s_zero_run)
		else $error("zero writes do not start at block base");
	AST_ZERO_STEP: assert property (zwr_valid_o && zwr_ready_i && r.zcnt != ZLAST
		|=> zwr_valid_o && zwr_addr_o == $past(zwr_addr_o) + XLEN'(CAP_BYTES))
		else $error("zero write does not advance one capability width");
	AST_LEN: assert property (accept && a_tag && !a_sealed && perm_ok && !len_ok && !pref_bad
		|=> resp_cause_o == CCB_CAUSE_LEN)
		else $error("bounds fault not reported");
endmodule

// File: tb/ccb_cache_model.sv
// ccb_cache_model: cache side of the zero-write port, answering promptly or with stalls.
// assumes: one core clock; slow_i is changed by the bench between operations.
`timescale 1ns/1ps
module ccb_cache_model (
	// clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// zero writes
	input wire logic zwr_valid_i,
	input wire logic [31:0] zwr_addr_i,
	output logic zwr_ready_o,
	// bench control and view
	input wire logic slow_i,
	output logic [7:0] count_o,
	output logic [31:0] first_o,
	output logic [31:0] last_o
);
	logic phase;
	// stall every other cycle when slow
	assign zwr_ready_o = ~slow_i | phase;
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			phase <= 1'b0;
			count_o <= 8'h00;
			first_o <= 32'h0000_0000;
			last_o <= 32'h0000_0000;
		end else begin
			phase <= ~phase;
			// each taken write is counted, and the first and last write addresses are kept
			if (zwr_valid_i && zwr_ready_o) begin
				count_o <= count_o + 8'h01;
				last_o <= zwr_addr_i;
				if (count_o == 8'h00) begin
					first_o <= zwr_addr_i;
				end
			end
		end
	end
endmodule

// File: tb/tb_top.sv
// tb_top: directed bench for the cache-block operation checker.
// assumes: ccb_check with default parameters, ccb_cache_model on the zero-write port.
`timescale 1ns/1ps
module tb_top;
	import ccb_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam ccb_op_t OCL = CCB_OP_CLEAN;
	localparam ccb_op_t OFL = CCB_OP_FLUSH;
	localparam ccb_op_t OIV = CCB_OP_INVAL;
	localparam ccb_op_t OZR = CCB_OP_ZERO;
	localparam ccb_op_t OPI = CCB_OP_PREF_I;
	localparam ccb_op_t OPR = CCB_OP_PREF_R;
	localparam ccb_cause_t KN = CCB_CAUSE_NONE;
	localparam logic [32:0] FULL = 33'h1_0000_0000;
	logic mclk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic req_valid = 1'b0;
	ccb_op_t req_op = CCB_OP_CLEAN;
	logic cm = 1'b0;
	logic [1:0] priv = 2'h3;
	logic [11:0] imm = 12'h000;
	logic [31:0] base = 32'h0000_0000;
	logic [31:0] bot = 32'h0000_0000;
	logic [31:0] a_addr = 32'h0000_0000;
	logic a_tag = 1'b0, a_seal = 1'b0, d_tag = 1'b0, d_seal = 1'b0, slow = 1'b0;
	logic [3:0] a_perm = 4'h0, d_perm = 4'h0;
	logic [32:0] a_top = 33'h0_0000_0000, d_top = 33'h0_0000_0000;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic req_ready, resp_valid, resp_fault, cmd_valid, zwr_valid, zwr_ready;
	logic awready, wready, bvalid, arready, rvalid;
	ccb_cause_t resp_cause;
	ccb_op_t cmd_op;
	logic [3:0] resp_type;
	logic [31:0] cmd_addr, zwr_addr, rdata, first, last;
	logic [1:0] bresp, rresp;
	logic [7:0] wr_count;
	int fails = 0;
	int checked = 0;
	int cycles = 0;
	ccb_check DUT (
		.mclk_i(mclk_i), .resetn_i(resetn_i), .req_valid_i(req_valid), .req_ready_o(req_ready), .req_op_i(req_op),
		.req_cap_mode_i(cm), .req_priv_i(priv), .req_imm_i(imm), .integer_base_reg_i(base), .acap_addr_i(a_addr),
		.acap_tag_i(a_tag), .acap_sealed_i(a_seal), .acap_perm_i(a_perm), .acap_bot_i(bot), .acap_top_i(a_top),
		.ddc_tag_i(d_tag), .ddc_sealed_i(d_seal), .ddc_perm_i(d_perm), .ddc_bot_i(bot), .ddc_top_i(d_top),
		.resp_valid_o(resp_valid), .resp_fault_o(resp_fault), .resp_cause_o(resp_cause), .resp_type_o(resp_type),
		.cmd_valid_o(cmd_valid), .cmd_op_o(cmd_op), .cmd_addr_o(cmd_addr), .zwr_valid_o(zwr_valid),
		.zwr_ready_i(zwr_ready), .zwr_addr_o(zwr_addr), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready)
	);
	ccb_cache_model cache (
		.mclk_i(mclk_i), .resetn_i(resetn_i), .zwr_valid_i(zwr_valid), .zwr_addr_i(zwr_addr), .zwr_ready_o(zwr_ready),
		.slow_i(slow), .count_o(wr_count), .first_o(first), .last_o(last)
	);
	always #12.5 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fails++;
			$display("ERROR timeout expected finish seen hang");
			summarize();
		end
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input string n, input logic [32:0] e, input logic [32:0] s);
		checked++;
		if (s !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	// authority on the selected side, the other side made unusable
	task automatic cap(input logic c, input logic t, input logic s, input logic [3:0] p, input logic [32:0] top);
		@(posedge mclk_i);
		cm <= c;
		a_tag <= c & t;
		a_seal <= c & s;
		a_perm <= c ? p : 4'h0;
		a_top <= c ? top : 33'h0_0000_0000;
		d_tag <= ~c & t;
		d_seal <= ~c & s;
		d_perm <= c ? 4'h0 : p;
		d_top <= c ? 33'h0_0000_0000 : top;
	endtask
	task automatic req(input ccb_op_t op, input logic [1:0] pr, input logic [11:0] im, input logic [31:0] ad,
		input ccb_cause_t ec, input ccb_op_t eo);
		logic pf;
		logic ev;
		logic [31:0] ea;
		pf = (op == OPI) || (op == OPR);
		ea = (ad + (pf ? {{20{im[11]}}, im} : 32'h0000_0000)) & 32'hFFFF_FFC0;
		ev = (ec == KN) && (op != OZR) && !(pf && im[4:0] != 5'h00);
		@(posedge mclk_i);
		req_valid <= 1'b1;
		req_op <= op;
		priv <= pr;
		imm <= im;
		a_addr <= cm ? ad : 32'h0000_0000;
		base <= cm ? 32'h0000_0000 : ad;
		@(negedge mclk_i);
		while (req_ready !== 1'b1) @(negedge mclk_i);
		@(posedge mclk_i);
		req_valid <= 1'b0;
		@(negedge mclk_i);
		chk("resp_valid", 1, resp_valid);
		chk("resp_fault", ec != KN, resp_fault);
		chk("resp_cause", ec, resp_cause);
		chk("resp_type", (ec != KN) ? CCB_TYPE_DATA : CCB_TYPE_NONE, resp_type);
		chk("cmd_valid", ev, cmd_valid);
		if (ev) begin
			chk("cmd_op", eo, cmd_op);
			chk("cmd_addr", ea, cmd_addr);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic a_ok, w_ok, b_ok;
		@(posedge mclk_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(negedge mclk_i);
			a_ok = awvalid & awready;
			w_ok = wvalid & wready;
			b_ok = bvalid;
			if (b_ok) chk("bresp", CCB_RESP_OKAY, bresp);
			@(posedge mclk_i);
			if (a_ok) awvalid <= 1'b0;
			if (w_ok) wvalid <= 1'b0;
			if (b_ok) begin
				bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
		logic a_ok, r_ok;
		@(posedge mclk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(negedge mclk_i);
			a_ok = arvalid & arready;
			r_ok = rvalid;
			if (r_ok) chk("rdata", e, rdata & m);
			if (r_ok) chk("rresp", er, rresp);
			@(posedge mclk_i);
			if (a_ok) arvalid <= 1'b0;
			if (r_ok) begin
				rready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge mclk_i);
		resetn_i <= 1'b1;
		axr(CCB_REG_ENV, 32'h0000_000F, 32'h0000_000F, CCB_RESP_OKAY);
		axr(8'h40, 32'h0000_0000, 32'hFFFF_FFFF, CCB_RESP_SLVERR);
		cap(1'b1, 1'b1, 1'b0, 4'hF, FULL);
		req(OCL, 2'h3, 12'h000, 32'h1000_0047, KN, OCL);
		req(OFL, 2'h0, 12'h000, 32'h1000_0080, KN, OFL);
		req(OIV, 2'h0, 12'h000, 32'h1000_00C0, KN, OIV);
		req(OPI, 2'h3, 12'hFE0, 32'h0000_1000, KN, OPI);
		req(OPR, 2'h3, 12'h7E0, 32'h0000_1000, KN, OPR);
		req(OPR, 2'h3, 12'h010, 32'h0000_1000, KN, OPR);
		cap(1'b0, 1'b1, 1'b0, 4'hF, FULL);
		req(OCL, 2'h3, 12'h000, 32'h2000_0100, KN, OCL);
		req(OIV, 2'h3, 12'h000, 32'h2000_0140, KN, OIV);
		@(posedge mclk_i);
		slow <= 1'b1;
		req(OZR, 2'h3, 12'h000, 32'h2000_0010, KN, OZR);
		req(OFL, 2'h3, 12'h000, 32'h2000_0040, KN, OFL);
		chk("zero_count", 8, wr_count);
		chk("zero_first", 32'h2000_0000, first);
		chk("zero_last", 32'h2000_0038, last);
		cap(1'b1, 1'b0, 1'b1, 4'h0, 33'h0_0000_0000);
		req(OCL, 2'h3, 12'h000, 32'h1000_0000, CCB_CAUSE_TAG, OCL);
		cap(1'b1, 1'b1, 1'b1, 4'h0, 33'h0_0000_0000);
		req(OZR, 2'h3, 12'h000, 32'h1000_0000, CCB_CAUSE_SEAL, OZR);
		cap(1'b1, 1'b1, 1'b0, 4'h2, 33'h0_1000_0020);
		req(OCL, 2'h3, 12'h000, 32'h1000_0000, CCB_CAUSE_PERM, OCL);
		cap(1'b1, 1'b1, 1'b0, 4'h4, FULL);
		req(OFL, 2'h3, 12'h000, 32'h1000_0000, CCB_CAUSE_PERM, OFL);
		cap(1'b1, 1'b1, 1'b0, 4'h2, FULL);
		req(OZR, 2'h3, 12'h000, 32'h1000_0000, CCB_CAUSE_PERM, OZR);
		cap(1'b1, 1'b1, 1'b0, 4'h6, FULL);
		req(OPI, 2'h3, 12'h000, 32'h1000_0000, CCB_CAUSE_PERM, OPI);
		req(OIV, 2'h3, 12'h000, 32'h1000_0000, CCB_CAUSE_PERM, OIV);
		cap(1'b1, 1'b1, 1'b0, 4'h9, FULL);
		req(OPR, 2'h3, 12'h000, 32'h1000_0000, CCB_CAUSE_PERM, OPR);
		cap(1'b1, 1'b1, 1'b0, 4'hF, 33'h0_1000_003F);
		req(OIV, 2'h3, 12'h000, 32'h1000_0000, CCB_CAUSE_LEN, OIV);
		req(OZR, 2'h3, 12'h000, 32'h1000_0000, CCB_CAUSE_LEN, OZR);
		req(OCL, 2'h3, 12'h000, 32'h1000_0000, CCB_CAUSE_LEN, OCL);
		req(OPR, 2'h3, 12'h000, 32'h1000_0000, CCB_CAUSE_LEN, OPR);
		axr(CCB_REG_STATUS, 32'h0000_0024, 32'h0000_003F, CCB_RESP_OKAY);
		cap(1'b1, 1'b1, 1'b0, 4'hF, 33'h0_1000_0040);
		req(OFL, 2'h3, 12'h000, 32'h1000_0000, KN, OFL);
		@(posedge mclk_i);
		bot <= 32'h1000_0040;
		req(OFL, 2'h3, 12'h000, 32'h1000_0000, CCB_CAUSE_LEN, OFL);
		@(posedge mclk_i);
		bot <= 32'h0000_0000;
		axw(CCB_REG_ENV, 32'h0000_0005);
		axr(CCB_REG_ENV, 32'h0000_0005, 32'h0000_000F, CCB_RESP_OKAY);
		cap(1'b1, 1'b1, 1'b0, 4'hF, FULL);
		req(OIV, 2'h1, 12'h000, 32'h1000_0000, KN, OFL);
		req(OIV, 2'h3, 12'h000, 32'h1000_0000, KN, OIV);
		axw(CCB_REG_ENV, 32'h0000_0004);
		req(OIV, 2'h0, 12'h000, 32'h1000_0000, KN, OFL);
		req(OIV, 2'h1, 12'h000, 32'h1000_0000, KN, OIV);
		cap(1'b1, 1'b1, 1'b0, 4'h6, FULL);
		req(OIV, 2'h0, 12'h000, 32'h1000_0000, CCB_CAUSE_PERM, OIV);
		summarize();
	end
endmodule
